// ### shared/oscsel_pkg.sv
// Purpose: constants and types for the oscillator select and doze control block
// Assumes: 16-bit registers on a plain address/strobe port, 100 MHz system clock
// Notes: unlock keys are written as 16-bit words; the key sits in the byte that it unlocks
// Notes on behaviour
// - current source field read-only, bits 14-12
// - requested source field, reset from configuration
// - freeze bit locks selections when permitted
// - monitor disabled: selections never locked
// - lock status reflects multiplier lock
// - lock status cleared on switch, non-multiplier modes
// - clock fail flag set, cleared by software or on switch start
// - secondary oscillator enable bit 1
// - switch request held until switch completes
// - interrupt clears ratio apply when recover set
// - doze ratio field selects 1:2^n
// - ratio apply clear forces 1:1
// - postscaler field divides by 2^n, reset 001
// - trim field six-bit two's complement
// - primary submode only from configuration
// - switching enabled only when config bit 1 is 0
// - switching disabled: current reports configured source
// - switching disabled: request held at 0
// - unimplemented bits ignore writes, read 0
// - same source request aborts, clears request
// - wait ten new-clock cycles, then switch
package oscsel_pkg;
  localparam logic [1:0] OFS_CONTROL = 2'h0;
  localparam logic [1:0] OFS_DIVIDER = 2'h1;
  localparam logic [1:0] OFS_TUNE    = 2'h2;

  localparam int CUR_LSB    = 12;
  localparam int REQ_LSB    = 8;
  localparam int FREEZE_BIT = 7;
  localparam int LOCK_BIT   = 5;
  localparam int FAIL_BIT   = 3;
  localparam int SEC_BIT    = 1;
  localparam int SWREQ_BIT  = 0;
  localparam int ROI_BIT    = 15;
  localparam int DOZE_LSB   = 12;
  localparam int APPLY_BIT  = 11;
  localparam int POST_LSB   = 8;

  localparam logic [2:0]  POST_RESET = 3'h1;
  localparam logic [7:0]  KEY_HI_A   = 8'h78;
  localparam logic [7:0]  KEY_HI_B   = 8'h9a;
  localparam logic [7:0]  KEY_LO_A   = 8'h46;
  localparam logic [7:0]  KEY_LO_B   = 8'h57;
  localparam int          SETTLE_CYCLES = 10;

  typedef enum logic [2:0] {
    SRC_FAST_RC        = 3'h0,
    SRC_FAST_RC_MULT   = 3'h1,
    SRC_PRIMARY        = 3'h2,
    SRC_PRIMARY_MULT   = 3'h3,
    SRC_SECONDARY      = 3'h4,
    SRC_LOW_POWER_RC   = 3'h5,
    SRC_RESERVED       = 3'h6,
    SRC_FAST_RC_POST   = 3'h7
  } oscsel_src_type;

  typedef enum logic [1:0] {
    SW_IDLE   = 2'h0,
    SW_START  = 2'h1,
    SW_SETTLE = 2'h2
  } oscsel_sw_type;

  typedef struct packed {
    logic [2:0] doze_ratio;
    logic [2:0] postscaler;
    logic [5:0] trim;
  } oscsel_div_type;
endpackage

// ### src/oscsel_ctrl.sv
// Purpose: oscillator source selection, switch sequencing and doze/postscale/trim registers
// Assumes: oscillator-side status inputs are asynchronous and are synchronised here
// Notes: new-clock cycles arrive as an asynchronous pulse on new_clk_tick_async, synchronised and counted on its rising edge
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module oscsel_ctrl (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [1:0]                 addr,
  input  wire logic [15:0]                wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [15:0]                rdata,
  input  wire logic [2:0]                 initial_source_cfg,
  input  wire logic [1:0]                 switch_monitor_cfg,
  input  wire logic [1:0]                 primary_submode_cfg,
  input  wire logic                       pll_locked_async,
  input  wire logic                       new_osc_ready_async,
  input  wire logic                       new_clk_tick_async,
  input  wire logic                       clock_fail_async,
  input  wire logic                       interrupt_event,
  output logic      [2:0]                 active_source,
  output logic      [1:0]                 primary_submode,
  output logic      [2:0]                 target_source,
  output logic                            secondary_osc_enable,
  output oscsel_pkg::oscsel_div_type      divider_setting,
  output logic                            doze_active
);
  logic [2:0] sync_lock_ff, sync_ready_ff, sync_tick_ff, sync_fail_ff;
  logic       lock_seen_ff, fail_seen_ff, tick_seen_ff, ready_seen_ff;
  logic [2:0] current_ff, requested_ff;
  logic       freeze_ff, lock_ff, fail_ff, sec_ff, swreq_ff;
  logic       roi_ff, apply_ff;
  logic [2:0] doze_ff, post_ff;
  logic [5:0] trim_ff;
  logic [1:0] unlock_hi_ff, unlock_lo_ff;
  logic [3:0] settle_ff;
  logic       cfg_taken_ff;
  logic [15:0] rdata_ff;
  oscsel_pkg::oscsel_sw_type sw_ff, nxt_sw;

  // filtered inputs: change counts once stages two and three agree
  wire lock_in  = (sync_lock_ff[1] == sync_lock_ff[2]) ? sync_lock_ff[2] : lock_seen_ff;
  wire ready_in = (sync_ready_ff[1] == sync_ready_ff[2]) ? sync_ready_ff[2] : ready_seen_ff;
  wire fail_in  = (sync_fail_ff[1] == sync_fail_ff[2]) ? sync_fail_ff[2] : fail_seen_ff;
  wire tick_lvl = (sync_tick_ff[1] == sync_tick_ff[2]) ? sync_tick_ff[2] : tick_seen_ff;
  wire tick_rise = tick_lvl & ~tick_seen_ff;
  wire fail_rise = fail_in & ~fail_seen_ff;

  // switching only when configuration bit programmed low
  wire switch_enabled = ~switch_monitor_cfg[1];
  wire monitor_enabled = (switch_monitor_cfg == 2'h0);
  // freeze only meaningful with monitor enabled
  wire frozen = freeze_ff & monitor_enabled;

  wire wr_ctl = wr_en && addr == oscsel_pkg::OFS_CONTROL;
  wire wr_div = wr_en && addr == oscsel_pkg::OFS_DIVIDER;
  wire wr_tun = wr_en && addr == oscsel_pkg::OFS_TUNE;
  wire key_hi_a = wr_ctl && wdata[15:8] == oscsel_pkg::KEY_HI_A;
  wire key_hi_b = wr_ctl && wdata[15:8] == oscsel_pkg::KEY_HI_B;
  wire key_lo_a = wr_ctl && wdata[7:0] == oscsel_pkg::KEY_LO_A;
  wire key_lo_b = wr_ctl && wdata[7:0] == oscsel_pkg::KEY_LO_B;
  // guarded write only straight after a two-write unlock
  wire hi_open = wr_ctl && unlock_hi_ff == 2'h2 && !key_hi_a;
  wire lo_open = wr_ctl && unlock_lo_ff == 2'h2 && !key_lo_a;
  wire req_write = hi_open && !frozen;
  wire sw_start = lo_open && wdata[oscsel_pkg::SWREQ_BIT] && switch_enabled && !frozen && !swreq_ff;

  function automatic logic uses_mult(input logic [2:0] src);
    uses_mult = (src == oscsel_pkg::SRC_PRIMARY_MULT) || (src == oscsel_pkg::SRC_FAST_RC_MULT);
  endfunction

  wire redundant = requested_ff == current_ff;
  wire settle_done = settle_ff == 4'(oscsel_pkg::SETTLE_CYCLES);
  wire switch_done = sw_ff == oscsel_pkg::SW_SETTLE && settle_done;

  // switch sequencer
  always_comb
  begin
    nxt_sw = sw_ff;
    unique case (sw_ff)
      oscsel_pkg::SW_IDLE:
      begin
        if (sw_start)
        begin
          nxt_sw = oscsel_pkg::SW_START;
        end
      end
      oscsel_pkg::SW_START:
      begin
        if (redundant)
        begin
          nxt_sw = oscsel_pkg::SW_IDLE;
        end
        else if (ready_in && (!uses_mult(requested_ff) || lock_in))
        begin
          nxt_sw = oscsel_pkg::SW_SETTLE;
        end
      end
      oscsel_pkg::SW_SETTLE:
      begin
        if (settle_done)
        begin
          nxt_sw = oscsel_pkg::SW_IDLE;
        end
      end
      default:
      begin
        nxt_sw = oscsel_pkg::SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync_lock_ff  <= 3'h0;
      sync_ready_ff <= 3'h0;
      sync_tick_ff  <= 3'h0;
      sync_fail_ff  <= 3'h0;
      lock_seen_ff  <= 1'b0;
      fail_seen_ff  <= 1'b0;
      tick_seen_ff  <= 1'b0;
      ready_seen_ff <= 1'b0;
    end
    else
    begin
      sync_lock_ff  <= {sync_lock_ff[1:0], pll_locked_async};
      sync_ready_ff <= {sync_ready_ff[1:0], new_osc_ready_async};
      sync_tick_ff  <= {sync_tick_ff[1:0], new_clk_tick_async};
      sync_fail_ff  <= {sync_fail_ff[1:0], clock_fail_async};
      lock_seen_ff  <= lock_in;
      fail_seen_ff  <= fail_in;
      tick_seen_ff  <= tick_lvl;
      ready_seen_ff <= ready_in;
    end
  end

  // unlock tracking: state 1 after first key, 2 after second key
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      unlock_hi_ff <= 2'h0;
      unlock_lo_ff <= 2'h0;
    end
    else if (wr_ctl)
    begin
      unlock_hi_ff <= key_hi_a ? 2'h1 : (unlock_hi_ff == 2'h1 && key_hi_b) ? 2'h2 : 2'h0;
      unlock_lo_ff <= key_lo_a ? 2'h1 : (unlock_lo_ff == 2'h1 && key_lo_b) ? 2'h2 : 2'h0;
    end
    else if (wr_en)
    begin
      unlock_hi_ff <= 2'h0;
      unlock_lo_ff <= 2'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sw_ff     <= oscsel_pkg::SW_IDLE;
      settle_ff <= 4'h0;
    end
    else
    begin
      sw_ff <= nxt_sw;
      if (sw_ff != oscsel_pkg::SW_SETTLE)
      begin
        settle_ff <= 4'h0;
      end
      else if (tick_rise && !settle_done)
      begin
        settle_ff <= settle_ff + 4'h1;
      end
    end
  end

  // control register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      current_ff   <= 3'h0;
      requested_ff <= 3'h0;
      cfg_taken_ff <= 1'b0;
      freeze_ff    <= 1'b0;
      lock_ff      <= 1'b0;
      fail_ff      <= 1'b0;
      sec_ff       <= 1'b0;
      swreq_ff     <= 1'b0;
    end
    else
    begin
      cfg_taken_ff <= 1'b1;
      // configured source captured after reset release
      if (!cfg_taken_ff || !switch_enabled)
      begin
        current_ff <= initial_source_cfg;
      end
      else if (switch_done)
      begin
        current_ff <= requested_ff;
      end
      if (!cfg_taken_ff)
      begin
        requested_ff <= initial_source_cfg;
      end
      else if (req_write && sw_ff == oscsel_pkg::SW_IDLE)
      begin
        requested_ff <= wdata[oscsel_pkg::REQ_LSB +: 3];
      end
      if (lo_open && wdata[oscsel_pkg::FREEZE_BIT])
      begin
        freeze_ff <= 1'b1;
      end
      if (lo_open)
      begin
        sec_ff <= wdata[oscsel_pkg::SEC_BIT];
      end
      // request held until done or abort
      if (!switch_enabled)
      begin
        swreq_ff <= 1'b0;
      end
      else if (sw_start)
      begin
        swreq_ff <= 1'b1;
      end
      else if (switch_done || (sw_ff == oscsel_pkg::SW_START && redundant))
      begin
        swreq_ff <= 1'b0;
      end
      if ((sw_ff == oscsel_pkg::SW_START && !redundant) || !uses_mult(current_ff))
      begin
        lock_ff <= 1'b0;
      end
      else
      begin
        lock_ff <= lock_in;
      end
      if (fail_rise && monitor_enabled)
      begin
        fail_ff <= 1'b1;
      end
      else if (sw_ff == oscsel_pkg::SW_START && !redundant)
      begin
        fail_ff <= 1'b0;
      end
      else if (lo_open && !wdata[oscsel_pkg::FAIL_BIT])
      begin
        fail_ff <= 1'b0;
      end
    end
  end

  // divider and tune registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      roi_ff   <= 1'b0;
      apply_ff <= 1'b0;
      doze_ff  <= 3'h0;
      post_ff  <= oscsel_pkg::POST_RESET;
      trim_ff  <= 6'h0;
    end
    else
    begin
      if (wr_div)
      begin
        roi_ff  <= wdata[oscsel_pkg::ROI_BIT];
        doze_ff <= wdata[oscsel_pkg::DOZE_LSB +: 3];
        post_ff <= wdata[oscsel_pkg::POST_LSB +: 3];
      end
      // interrupt recovery wins over a write
      if (interrupt_event && roi_ff)
      begin
        apply_ff <= 1'b0;
      end
      else if (wr_div)
      begin
        apply_ff <= wdata[oscsel_pkg::APPLY_BIT];
      end
      if (wr_tun)
      begin
        trim_ff <= wdata[5:0];
      end
    end
  end

  wire [15:0] ctl_word = {1'b0, current_ff, 1'b0, requested_ff, freeze_ff, 1'b0, lock_ff,
                          1'b0, fail_ff, 1'b0, sec_ff, swreq_ff};
  wire [15:0] div_word = {roi_ff, doze_ff, apply_ff, post_ff, 8'h00};
  wire [15:0] tun_word = {10'h000, trim_ff};
  wire [15:0] rd_mux = (addr == oscsel_pkg::OFS_CONTROL) ? ctl_word :
                       (addr == oscsel_pkg::OFS_DIVIDER) ? div_word :
                       (addr == oscsel_pkg::OFS_TUNE)    ? tun_word : 16'h0000;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= rd_en ? rd_mux : 16'h0000;
    end
  end

  assign rdata = rdata_ff;
  assign active_source = current_ff;
  assign primary_submode = primary_submode_cfg;
  assign target_source = requested_ff;
  assign secondary_osc_enable = sec_ff;
  assign divider_setting = '{doze_ratio: apply_ff ? doze_ff : 3'h0, postscaler: post_ff, trim: trim_ff};
  assign doze_active = apply_ff;

  // ratio forced to 1:1 while apply clear
  a_doze_forced_unity: assert property (@(posedge clk) disable iff (!reset_n)
    !doze_active |-> divider_setting.doze_ratio == 3'h0)
    else $error("doze ratio not 1:1 while apply clear");

  a_roi_clears_apply: assert property (@(posedge clk) disable iff (!reset_n)
    (interrupt_event && roi_ff) |=> !apply_ff)
    else $error("interrupt recovery did not clear apply");

  // request held low with switching disabled
  a_swreq_held_low: assert property (@(posedge clk) disable iff (!reset_n)
    !switch_enabled |=> !swreq_ff)
    else $error("switch request set while switching disabled");

  a_cur_follows_cfg: assert property (@(posedge clk) disable iff (!reset_n)
    (!switch_enabled && $stable(initial_source_cfg)) |=> current_ff == $past(initial_source_cfg))
    else $error("current source not from configuration");

  sequence s_redundant_req;
    sw_ff == oscsel_pkg::SW_START && redundant;
  endsequence
  // redundant switch aborts and clears request
  a_redundant_abort: assert property (@(posedge clk) disable iff (!reset_n)
    s_redundant_req |=> !swreq_ff && sw_ff == oscsel_pkg::SW_IDLE)
    else $error("redundant switch not aborted");

  a_switch_copies: assert property (@(posedge clk) disable iff (!reset_n)
    (switch_done && switch_enabled) |=> current_ff == $past(requested_ff) && !swreq_ff)
    else $error("switch completion wrong");

  a_swreq_stays: assert property (@(posedge clk) disable iff (!reset_n)
    (swreq_ff && sw_ff == oscsel_pkg::SW_SETTLE && !settle_done && switch_enabled) |=> swreq_ff)
    else $error("switch request dropped early");

  a_lock_no_mult: assert property (@(posedge clk) disable iff (!reset_n)
    !uses_mult(current_ff) |=> !lock_ff)
    else $error("lock status set in non-multiplier mode");

  a_fail_sets: assert property (@(posedge clk) disable iff (!reset_n)
    (fail_rise && monitor_enabled) |=> fail_ff)
    else $error("clock fail not flagged");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
    $past(rd_en) |-> (rdata[15] | rdata[11] | rdata[6] | rdata[4] | rdata[2]) == 1'b0
      || $past(addr) != oscsel_pkg::OFS_CONTROL)
    else $error("unimplemented bit read non-zero");
endmodule

// ### verification/oscsel_ctrl_tb.sv
// Purpose: self-checking bench for the oscillator select and doze control block
// Assumes: word-indexed registers on a plain strobe port, read data one cycle after the read strobe
// Notes: read results go through an expectation queue; other outputs are compared directly
`timescale 1ns/1ps
module oscsel_ctrl_tb;
  logic                      clk;
  logic                      reset_n;
  logic [1:0]                addr;
  logic [15:0]               wdata;
  logic                      wr_en;
  logic                      rd_en;
  logic [15:0]               rdata;
  logic [2:0]                initial_source_cfg;
  logic [1:0]                switch_monitor_cfg;
  logic [1:0]                primary_submode_cfg;
  logic                      pll_locked_async;
  logic                      new_osc_ready_async;
  logic                      new_clk_tick_async;
  logic                      clock_fail_async;
  logic                      interrupt_event;
  logic [2:0]                active_source;
  logic [1:0]                primary_submode;
  logic [2:0]                target_source;
  logic                      secondary_osc_enable;
  oscsel_pkg::oscsel_div_type divider_setting;
  logic                      doze_active;
  logic [15:0]               exp_q[$];
  logic                      rd_d;
  int                        failures;
  int                        checks;
  logic [15:0]               d;
  logic [15:0]               t;

  oscsel_ctrl DUT (
    .clk                  (clk),
    .reset_n              (reset_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rdata                (rdata),
    .initial_source_cfg   (initial_source_cfg),
    .switch_monitor_cfg   (switch_monitor_cfg),
    .primary_submode_cfg  (primary_submode_cfg),
    .pll_locked_async     (pll_locked_async),
    .new_osc_ready_async  (new_osc_ready_async),
    .new_clk_tick_async   (new_clk_tick_async),
    .clock_fail_async     (clock_fail_async),
    .interrupt_event      (interrupt_event),
    .active_source        (active_source),
    .primary_submode      (primary_submode),
    .target_source        (target_source),
    .secondary_osc_enable (secondary_osc_enable),
    .divider_setting      (divider_setting),
    .doze_active          (doze_active)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read data watcher: oldest expectation against the data cycle
  always @(posedge clk)
  begin
    rd_d <= rd_en;
    if (rd_d === 1'b1)
      chk(rdata, exp_q.pop_front());
  end

  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic unl_hi();
    wr(2'h0, {oscsel_pkg::KEY_HI_A, 8'h00});
    wr(2'h0, {oscsel_pkg::KEY_HI_B, 8'h00});
  endtask

  task automatic unl_lo();
    wr(2'h0, {8'h00, oscsel_pkg::KEY_LO_A});
    wr(2'h0, {8'h00, oscsel_pkg::KEY_LO_B});
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      new_clk_tick_async <= 1'b1;
      repeat (3) @(posedge clk);
      new_clk_tick_async <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic do_reset(input logic [1:0] cfg, input logic [2:0] src);
    @(posedge clk);
    reset_n            <= 1'b0;
    switch_monitor_cfg <= cfg;
    initial_source_cfg <= src;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic done_t(input string name);
    repeat (3) @(posedge clk);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    repeat (3) @(posedge clk);
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #300000;
    failures++;
    stop_test();
  end

  initial
  begin
    reset_n = 1'b0; addr = 2'h0; wdata = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
    initial_source_cfg = 3'h7; switch_monitor_cfg = 2'h0; primary_submode_cfg = 2'h0;
    pll_locked_async = 1'b0; new_osc_ready_async = 1'b0; new_clk_tick_async = 1'b0;
    clock_fail_async = 1'b0; interrupt_event = 1'b0; failures = 0; checks = 0;
    void'($urandom(27));
    do_reset(2'h0, 3'h7);
    rd(2'h0, 16'h7700);
    rd(2'h1, 16'h0100);
    rd(2'h2, 16'h0000);
    wr(2'h3, 16'hffff);
    rd(2'h3, 16'h0000);
    done_t("reset_values");
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($urandom);
      t = 16'($urandom);
      wr(2'h1, d);
      wr(2'h2, t);
      rd(2'h1, d & 16'hff00);
      rd(2'h2, t & 16'h003f);
      chk({4'h0, divider_setting}, {4'h0, (d[11] ? d[14:12] : 3'h0), d[10:8], t[5:0]});
      chk({15'h0, doze_active}, {15'h0, d[11]});
    end
    done_t("divider_tune");
    wr(2'h1, 16'h9b00);
    @(posedge clk) interrupt_event <= 1'b1;
    @(posedge clk) interrupt_event <= 1'b0;
    @(posedge clk);
    chk({15'h0, doze_active}, 16'h0000);
    chk({13'h0, divider_setting.doze_ratio}, 16'h0000);
    rd(2'h1, 16'h9300);
    wr(2'h1, 16'h1b00);
    @(posedge clk) interrupt_event <= 1'b1;
    @(posedge clk) interrupt_event <= 1'b0;
    rd(2'h1, 16'h1b00);
    done_t("recover_on_interrupt");
    wr(2'h0, 16'h0500);
    wr(2'h0, 16'h7800);
    wr(2'h0, 16'h1200);
    wr(2'h0, 16'h0500);
    rd(2'h0, 16'h7700);
    done_t("guarded_write");
    unl_hi();
    wr(2'h0, 16'h0000);
    unl_lo();
    wr(2'h0, 16'h0001);
    rd(2'h0, 16'h7001);
    tick(12);
    rd(2'h0, 16'h7001);
    new_osc_ready_async <= 1'b1;
    repeat (6) @(posedge clk);
    tick(5);
    rd(2'h0, 16'h7001);
    tick(4);
    rd(2'h0, 16'h7001);
    tick(2);
    repeat (6) @(posedge clk);
    rd(2'h0, 16'h0000);
    chk({13'h0, active_source}, 16'h0000);
    // multiplier reached via plain fast rc
    pll_locked_async <= 1'b1;
    unl_hi();
    wr(2'h0, 16'h0100);
    unl_lo();
    wr(2'h0, 16'h0001);
    tick(12);
    repeat (6) @(posedge clk);
    rd(2'h0, 16'h1120);
    unl_hi();
    wr(2'h0, 16'h0000);
    unl_lo();
    wr(2'h0, 16'h0001);
    rd(2'h0, 16'h1001);
    tick(12);
    repeat (6) @(posedge clk);
    rd(2'h0, 16'h0000);
    done_t("switching");
    unl_lo();
    wr(2'h0, 16'h0057);
    repeat (3) @(posedge clk);
    rd(2'h0, 16'h0002);
    chk({15'h0, secondary_osc_enable}, 16'h0001);
    clock_fail_async <= 1'b1;
    repeat (6) @(posedge clk);
    rd(2'h0, 16'h000a);
    unl_lo();
    wr(2'h0, 16'h0002);
    rd(2'h0, 16'h0002);
    clock_fail_async <= 1'b0;
    done_t("abort_enable_fail");
    unl_lo();
    wr(2'h0, 16'h0082);
    rd(2'h0, 16'h0082);
    unl_hi();
    wr(2'h0, 16'h0500);
    rd(2'h0, 16'h0082);
    unl_lo();
    wr(2'h0, 16'h0002);
    rd(2'h0, 16'h0082);
    chk({13'h0, target_source}, 16'h0000);
    done_t("freeze");
    do_reset(2'h1, 3'h0);
    unl_lo();
    wr(2'h0, 16'h0080);
    unl_hi();
    wr(2'h0, 16'h0500);
    repeat (2) @(posedge clk);
    chk({13'h0, target_source}, 16'h0005);
    done_t("monitor_off");
    primary_submode_cfg <= 2'($urandom);
    do_reset(2'h3, 3'h2);
    rd(2'h0, 16'h2200);
    unl_lo();
    wr(2'h0, 16'h0001);
    rd(2'h0, 16'h2200);
    chk({13'h0, active_source}, 16'h0002);
    chk({14'h0, primary_submode}, {14'h0, primary_submode_cfg});
    done_t("switching_off");
    stop_test();
  end
endmodule
